// ---- design/hs_switch_regs.vh ----
// constants for the high-side switch control block
`ifndef HS_SWITCH_REGS_VH
`define HS_SWITCH_REGS_VH
// output configuration codes (3 bits per output)
`define CFG_OFF        3'h0
`define CFG_ON         3'h1
`define CFG_TIMER1     3'h2
`define CFG_TIMER2     3'h3
`define CFG_GEN1       3'h4
`define CFG_GEN2       3'h5
// device operating modes
`define MODE_NORMAL    3'h0
`define MODE_STOP      3'h1
`define MODE_SLEEP     3'h2
`define MODE_RESTART   3'h3
`define MODE_FAILSAFE  3'h4
// clock and timing
`define CLOCK_HZ       250000000
`define GEN_SLOW_HZ    200
`define GEN_FAST_HZ    400
`define OL_FILTER_US   64
`define OC_FILTER_US   16
// cycles per pwm counter step (256 steps per period), rounded down
`define GEN_FAST_STEP  (`CLOCK_HZ / (`GEN_FAST_HZ * 256))
// filter counts in clock cycles
`define OL_FILTER_CYC  (`OL_FILTER_US * (`CLOCK_HZ / 1000000))
`define OC_FILTER_CYC  (`OC_FILTER_US * (`CLOCK_HZ / 1000000))
`endif

// ---- design/pwm_gen.v ----
// one 8-bit pwm generator with 200/400 Hz selection
`timescale 1ns/1ps
`default_nettype none
module pwm_gen (
   input  wire       clock,       // system clock
   input  wire       rst,         // synchronous reset
   input  wire       fast_tick,   // 400 Hz step enable
   input  wire [7:0] duty,        // duty code
   input  wire       freq_fast,   // 1 selects 400 Hz
   output reg        wave         // pwm waveform
);
   reg [7:0] period_count;        // free-running period counter
   reg       half;                // halves step rate for 200 Hz

   // step counter, every tick fast, every other tick slow
   always @(posedge clock) begin
      if (rst) begin
         period_count <= 8'h00;
         half         <= 1'b0;
         wave         <= 1'b0;
      end else begin
         if (fast_tick) begin
            half <= ~half;
            if (freq_fast || half) begin
               period_count <= period_count + 8'h01;
            end
         end
         wave <= (period_count < duty);
      end
   end
endmodule // pwm_gen
`default_nettype wire

// ---- design/high_side_switch_control.v ----
// four-channel high-side switch control with pwm and protection
`timescale 1ns/1ps
`include "hs_switch_regs.vh"
`default_nettype none
module high_side_switch_control #(
   parameter OL_FILTER = `OL_FILTER_CYC, // open-load filter cycles
   parameter OC_FILTER = `OC_FILTER_CYC, // overcurrent filter cycles
   parameter GEN_STEP  = `GEN_FAST_STEP  // cycles per 400 Hz step
) (
   input  wire        clock,                    // 250 MHz clock
   input  wire        rst,                      // synchronous reset
   input  wire [2:0]  device_mode,              // operating mode
   input  wire        cfg_write,                // config write strobe
   input  wire [11:0] cfg_data,                 // 4 x 3-bit configs
   input  wire        duty_write,               // duty/freq strobe
   input  wire [7:0]  gen1_duty_in,             // generator 1 duty
   input  wire [7:0]  gen2_duty_in,             // generator 2 duty
   input  wire [1:0]  gen_freq_in,              // 1 = 400 Hz each
   input  wire        ov_shutdown_enable,       // 1 disables ov off
   input  wire        uv_shutdown_enable,       // 1 disables uv off
   input  wire        volt_fault_recovery_en,   // resume after fault
   input  wire        timer1_wave,              // timer 1 output
   input  wire        timer2_wave,              // timer 2 output
   input  wire        supply_ov_pin,            // async comparator
   input  wire        supply_uv_pin,            // async comparator
   input  wire [3:0]  overcurrent_pin,          // async per output
   input  wire [3:0]  undercurrent_pin,         // async per output
   input  wire [3:0]  oc_clear,                 // clear oc flags
   input  wire [3:0]  ol_clear,                 // clear ol flags
   input  wire        supply_flag_clear,        // clear supply flags
   output reg  [3:0]  switched_output,          // switch drives
   output wire [11:0] output_ctrl,              // current configs
   output reg  [7:0]  gen1_duty,                // stored duty 1
   output reg  [7:0]  gen2_duty,                // stored duty 2
   output reg  [1:0]  gen_freq_select,          // stored freq select
   output reg  [3:0]  output_overcurrent_flag,  // sticky oc flags
   output reg  [3:0]  openload_flag,            // sticky ol flags
   output reg         supply_overvoltage_flag,  // sticky ov flag
   output reg         supply_undervoltage_flag  // sticky uv flag
);
   reg  [2:0]  cfg [0:3];       // per-output configuration
   reg  [1:0]  ov_meta;         // sync stage 1: uv, ov
   reg         ov_sync;         // synchronised overvoltage
   reg         uv_sync;         // synchronised undervoltage
   reg  [3:0]  oc_meta;         // overcurrent sync stage 1
   reg  [3:0]  oc_sync;         // overcurrent sync stage 2
   reg  [3:0]  ul_meta;         // undercurrent sync stage 1
   reg  [3:0]  ul_sync;         // undercurrent sync stage 2
   reg  [31:0] step_count;      // divider for pwm step
   reg         fast_tick;       // 400 Hz step enable
   reg  [31:0] oc_count [0:3];  // overcurrent filters
   reg  [31:0] ol_count [0:3];  // open-load filters
   reg         fault_prev;      // supply fault last cycle
   wire        gen1_wave;       // generator 1 waveform
   wire        gen2_wave;       // generator 2 waveform
   wire        ov_off;          // overvoltage shutdown active
   wire        uv_off;          // undervoltage shutdown active
   wire        volt_off;        // any supply shutdown
   wire        volt_clear;      // fault just ended, no recovery
   wire        forced_off;      // restart or fail-safe
   wire        normal;          // normal mode
   reg  [3:0]  sel;             // selected source per output
   reg  [3:0]  oc_trip;         // filter expired per output
   // one loop index per process, so no two processes share one
   integer     i_sel;           // loop index, source select
   integer     i_trip;          // loop index, trip decode
   integer     i_oc;            // loop index, oc filters
   integer     i_cfg;           // loop index, config store
   integer     i_drv;           // loop index, output drive
   integer     i_ol;            // loop index, open-load filters
   integer     i_flag;          // loop index, status flags

   assign output_ctrl = {cfg[3], cfg[2], cfg[1], cfg[0]};
   assign normal      = (device_mode == `MODE_NORMAL);
   assign forced_off  = (device_mode == `MODE_RESTART) ||
                        (device_mode == `MODE_FAILSAFE);
   assign ov_off   = ov_sync && !ov_shutdown_enable;
   assign uv_off   = uv_sync && !uv_shutdown_enable;
   assign volt_off = ov_off || uv_off;
   // fault just ended and no recovery wanted
   assign volt_clear = fault_prev && !volt_off && !volt_fault_recovery_en;

   // two-stage synchronisers for analog comparator inputs
   always @(posedge clock) begin
      if (rst) begin
         ov_meta <= 2'h0;
         ov_sync <= 1'b0;
         uv_sync <= 1'b0;
         oc_meta <= 4'h0;
         oc_sync <= 4'h0;
         ul_meta <= 4'h0;
         ul_sync <= 4'h0;
      end else begin
         ov_meta <= {supply_uv_pin, supply_ov_pin};
         ov_sync <= ov_meta[0];
         uv_sync <= ov_meta[1];
         oc_meta <= overcurrent_pin;
         oc_sync <= oc_meta;
         ul_meta <= undercurrent_pin;
         ul_sync <= ul_meta;
      end
   end

   // 400 Hz step divider, one-cycle enable
   always @(posedge clock) begin
      if (rst || step_count == GEN_STEP - 1) begin
         step_count <= 32'h0000_0000;
      end else begin
         step_count <= step_count + 32'h0000_0001;
      end
   end
   always @(posedge clock) begin
      if (rst) begin
         fast_tick <= 1'b0;
      end else begin
         fast_tick <= (step_count == GEN_STEP - 1);
      end
   end

   // duty and frequency settings, normal mode only
   always @(posedge clock) begin
      if (rst) begin
         gen1_duty       <= 8'h00;
         gen2_duty       <= 8'h00;
         gen_freq_select <= 2'h0;
      end else if (duty_write && normal) begin
         gen1_duty       <= gen1_duty_in;
         gen2_duty       <= gen2_duty_in;
         gen_freq_select <= gen_freq_in;
      end
   end

   pwm_gen u_gen1 (
      .clock     (clock),
      .rst       (rst),
      .fast_tick (fast_tick),
      .duty      (gen1_duty),
      .freq_fast (gen_freq_select[0]),
      .wave      (gen1_wave)
   );
   pwm_gen u_gen2 (
      .clock     (clock),
      .rst       (rst),
      .fast_tick (fast_tick),
      .duty      (gen2_duty),
      .freq_fast (gen_freq_select[1]),
      .wave      (gen2_wave)
   );

   // source selection per output
   always @* begin
      for (i_sel = 0; i_sel < 4; i_sel = i_sel + 1) begin
         case (cfg[i_sel])
            `CFG_ON:     sel[i_sel] = 1'b1;
            `CFG_TIMER1: sel[i_sel] = timer1_wave;
            `CFG_TIMER2: sel[i_sel] = timer2_wave;
            `CFG_GEN1:   sel[i_sel] = gen1_wave;
            `CFG_GEN2:   sel[i_sel] = gen2_wave;
            default:     sel[i_sel] = 1'b0;
         endcase
      end
   end

   // overcurrent filters, counting while output on and over limit
   always @(posedge clock) begin
      for (i_oc = 0; i_oc < 4; i_oc = i_oc + 1) begin
         if (rst || !switched_output[i_oc] || !oc_sync[i_oc]) begin
            oc_count[i_oc] <= 32'h0000_0000;
         end else if (oc_count[i_oc] < OC_FILTER) begin
            oc_count[i_oc] <= oc_count[i_oc] + 32'h0000_0001;
         end
      end
   end
   always @* begin
      for (i_trip = 0; i_trip < 4; i_trip = i_trip + 1) begin
         oc_trip[i_trip] = (oc_count[i_trip] >= OC_FILTER);
      end
   end

   // configuration store with mode, fault and overcurrent effects
   always @(posedge clock) begin
      if (rst) begin
         for (i_cfg = 0; i_cfg < 4; i_cfg = i_cfg + 1) begin
            cfg[i_cfg] <= `CFG_OFF;
         end
         fault_prev <= 1'b0;
      end else begin
         fault_prev <= volt_off;
         // off wins over a write in the same cycle
         for (i_cfg = 0; i_cfg < 4; i_cfg = i_cfg + 1) begin
            if (oc_trip[i_cfg]) begin
               cfg[i_cfg] <= `CFG_OFF;
            end else if (volt_clear) begin
               cfg[i_cfg] <= `CFG_OFF;
            end else if (cfg_write && normal) begin
               cfg[i_cfg] <= cfg_data[3*i_cfg +: 3];
            end
         end
      end
   end

   // output drive; prior config keeps running in low power
   always @(posedge clock) begin
      if (rst) begin
         switched_output <= 4'h0;
      end else begin
         for (i_drv = 0; i_drv < 4; i_drv = i_drv + 1) begin
            // no one-cycle pulse as a fault ends
            switched_output[i_drv] <= sel[i_drv] && !forced_off &&
                                      !volt_off && !volt_clear &&
                                      !oc_trip[i_drv];
         end
      end
   end

   // open-load filters, only while output on
   always @(posedge clock) begin
      for (i_ol = 0; i_ol < 4; i_ol = i_ol + 1) begin
         if (rst || !switched_output[i_ol] || !ul_sync[i_ol]) begin
            ol_count[i_ol] <= 32'h0000_0000;
         end else if (ol_count[i_ol] < OL_FILTER) begin
            ol_count[i_ol] <= ol_count[i_ol] + 32'h0000_0001;
         end
      end
   end

   // sticky status flags, set wins over clear
   always @(posedge clock) begin
      if (rst) begin
         output_overcurrent_flag  <= 4'h0;
         openload_flag            <= 4'h0;
         supply_overvoltage_flag  <= 1'b0;
         supply_undervoltage_flag <= 1'b0;
      end else begin
         for (i_flag = 0; i_flag < 4; i_flag = i_flag + 1) begin
            if (oc_trip[i_flag]) begin
               output_overcurrent_flag[i_flag] <= 1'b1;
            end else if (oc_clear[i_flag]) begin
               output_overcurrent_flag[i_flag] <= 1'b0;
            end
            if (ol_count[i_flag] >= OL_FILTER) begin
               openload_flag[i_flag] <= 1'b1;
            end else if (ol_clear[i_flag]) begin
               openload_flag[i_flag] <= 1'b0;
            end
         end
         // only supply flags for supply faults
         if (ov_sync) begin
            supply_overvoltage_flag <= 1'b1;
         end else if (supply_flag_clear) begin
            supply_overvoltage_flag <= 1'b0;
         end
         if (uv_sync) begin
            supply_undervoltage_flag <= 1'b1;
         end else if (supply_flag_clear) begin
            supply_undervoltage_flag <= 1'b0;
         end
      end
   end
endmodule // high_side_switch_control
`default_nettype wire

// ---- testbench/hs_switch_sva.sv ----
// assertion checker for the high-side switch control block
`timescale 1ns/1ps
`include "hs_switch_regs.vh"
`default_nettype none
module hs_switch_sva #(
   parameter OC_FILTER = 8 // overcurrent filter cycles
) (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic [2:0]  device_mode,
   input wire logic        cfg_write,
   input wire logic [11:0] cfg_data,
   input wire logic        ov_shutdown_enable,
   input wire logic        supply_ov_pin,
   input wire logic [3:0]  overcurrent_pin,
   input wire logic [3:0]  ol_clear,
   input wire logic [3:0]  switched_output,
   input wire logic [11:0] output_ctrl,
   input wire logic [3:0]  output_overcurrent_flag,
   input wire logic [3:0]  openload_flag,
   input wire logic        supply_overvoltage_flag,
   input wire logic        supply_undervoltage_flag
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [15:0] oc_run; // cycles output 0 stays on into a short
   // count how long a short on output 0 goes unanswered
   always @(posedge clock) begin
      if (rst || !(overcurrent_pin[0] && switched_output[0]))
         oc_run <= 16'h0000;
      else
         oc_run <= oc_run + 16'h0001;
   end
   sequence s_fail_mode;
      (device_mode == `MODE_RESTART || device_mode == `MODE_FAILSAFE) [*2];
   endsequence
   sequence s_ov_live;
      (supply_ov_pin && !ov_shutdown_enable) [*4];
   endsequence
   a_fail_mode_off: assert property (s_fail_mode |=> switched_output == 0)
      else $error("output on in restart or fail-safe");
   a_cfg_refused: assert property (cfg_write && device_mode != `MODE_NORMAL
      |=> (output_ctrl & ~$past(output_ctrl)) == 12'h000)
      else $error("config changed outside normal mode");
   a_cfg_taken: assert property (cfg_write && device_mode == `MODE_NORMAL
      && !supply_overvoltage_flag && !supply_undervoltage_flag
      && overcurrent_pin == 4'h0 |=> output_ctrl == $past(cfg_data))
      else $error("config write not taken");
   a_ov_shutdown: assert property (s_ov_live |=> switched_output == 4'h0)
      else $error("output on during overvoltage");
   a_ov_flag_only: assert property ((supply_ov_pin
      && overcurrent_pin == 4'h0) [*3] |=> supply_overvoltage_flag
      && $stable(output_overcurrent_flag))
      else $error("overvoltage flagged wrongly");
   a_oc_trip_clears: assert property ($rose(output_overcurrent_flag[0])
      |-> output_ctrl[2:0] == `CFG_OFF ##[0:1] !switched_output[0])
      else $error("overcurrent trip left config or output");
   a_oc_bound: assert property (oc_run < OC_FILTER + 6)
      else $error("short not switched off in time");
   a_ol_sticky: assert property (openload_flag[0] && !ol_clear[0]
      |=> openload_flag[0])
      else $error("open-load flag dropped by itself");
   a_ol_keeps_on: assert property ($rose(openload_flag[1])
      && output_ctrl[5:3] == `CFG_ON |-> switched_output[1] [*2])
      else $error("open load switched output off");
endmodule // hs_switch_sva
bind high_side_switch_control hs_switch_sva #(.OC_FILTER(OC_FILTER)) i_sva (.*);
`default_nettype wire

// ---- testbench/hs_load_model.sv ----
// load model for the four switched outputs
`timescale 1ns/1ps
`default_nettype none
module hs_load_model (
   input  wire logic [3:0] switched_output,  // switch drives
   input  wire logic [3:0] short_load,       // loads drawing too much
   input  wire logic [3:0] open_load,        // loads that are missing
   output wire logic [3:0] overcurrent_pin,  // current above limit
   output wire logic [3:0] undercurrent_pin  // current below limit
);
   // a load only draws current while its switch is on, so an open
   // load or a switched-off output reads as below the open-load limit
   assign overcurrent_pin  = switched_output & short_load;
   assign undercurrent_pin = ~switched_output | open_load;
endmodule // hs_load_model
`default_nettype wire

// ---- testbench/tb_high_side_switch_control.sv ----
// self-checking bench for the high-side switch control block
`timescale 1ns/1ps
`include "hs_switch_regs.vh"
`default_nettype none
module tb_high_side_switch_control;
   logic        clock, rst, cfg_write, duty_write, t1, t2, sf_clr;
   logic        ov_dis, uv_dis, rec_en, ov_pin, uv_pin;
   logic [2:0]  mode;
   logic [11:0] cfg;
   logic [7:0]  d1, d2;
   logic [1:0]  fsel;
   logic [3:0]  shrt, opn, oc_clr, ol_clr;
   wire  [3:0]  hs, ocf, olf, oc_pin, uc_pin;
   wire  [11:0] ctrl;
   wire  [7:0]  gd1, gd2;
   wire  [1:0]  gfs;
   wire         ovf, uvf;
   integer      miscompares, checks, n, c2, c3, r2, r3;
   logic [3:0]  p;  // outputs one cycle back, for pulse counting
   // 250 MHz clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // small filters and step keep the run short
   high_side_switch_control #(.OL_FILTER(8), .OC_FILTER(8), .GEN_STEP(2))
   i_high_side_switch_control (.clock(clock), .rst(rst),
      .device_mode(mode), .cfg_write(cfg_write), .cfg_data(cfg),
      .duty_write(duty_write), .gen1_duty_in(d1), .gen2_duty_in(d2),
      .gen_freq_in(fsel), .ov_shutdown_enable(ov_dis),
      .uv_shutdown_enable(uv_dis), .volt_fault_recovery_en(rec_en),
      .timer1_wave(t1), .timer2_wave(t2), .supply_ov_pin(ov_pin),
      .supply_uv_pin(uv_pin), .overcurrent_pin(oc_pin),
      .undercurrent_pin(uc_pin), .oc_clear(oc_clr), .ol_clear(ol_clr),
      .supply_flag_clear(sf_clr), .switched_output(hs), .output_ctrl(ctrl),
      .gen1_duty(gd1), .gen2_duty(gd2), .gen_freq_select(gfs),
      .output_overcurrent_flag(ocf), .openload_flag(olf),
      .supply_overvoltage_flag(ovf), .supply_undervoltage_flag(uvf));
   hs_load_model i_hs_load_model (.switched_output(hs), .short_load(shrt),
      .open_load(opn), .overcurrent_pin(oc_pin), .undercurrent_pin(uc_pin));
   // compare one value and count it
   task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      checks = checks + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task step(input integer k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task wr_cfg(input logic [11:0] d);
      @(posedge clock);
      cfg_write <= 1'b1;
      cfg <= d;
      @(posedge clock);
      cfg_write <= 1'b0;
      step(2);
   endtask
   // program duties, then count on-cycles of outputs 2 and 3
   task pwm_run(input logic [7:0] a, input logic [7:0] b, input logic [1:0] f,
                input logic [11:0] e2, input logic [11:0] e3);
      @(posedge clock);
      duty_write <= 1'b1;
      {d1, d2, fsel} <= {a, b, f};
      @(posedge clock);
      duty_write <= 1'b0;
      step(1);
      chk("duty1", {4'h0, a}, {4'h0, gd1});
      chk("duty2", {4'h0, b}, {4'h0, gd2});
      chk("freq", {10'h000, f}, {10'h000, gfs});
      {c2, c3, r2, r3} = 0;
      step(1);
      p = hs;
      for (n = 0; n < 1024; n = n + 1) begin
         step(1);
         c2 = c2 + hs[2];
         c3 = c3 + hs[3];
         r2 = r2 + (hs[2] & !p[2]);
         r3 = r3 + (hs[3] & !p[3]);
         p = hs;
      end
      chk("gen1 on", e2, c2[11:0]);
      chk("gen2 on", e3, c3[11:0]);
      chk("gen1 pulses", f[0] ? 12'h002 : 12'h001, r2[11:0]);
      chk("gen2 pulses", f[1] ? 12'h002 : 12'h001, r3[11:0]);
   endtask
   task give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      {miscompares, checks} = 0;
      {rst, cfg_write, duty_write, t1, t2, sf_clr} = 6'b100000;
      {ov_dis, uv_dis, rec_en, ov_pin, uv_pin} = 5'b00100;
      {mode, cfg, d1, d2, fsel} = 0;
      {shrt, opn, oc_clr, ol_clr} = 0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      step(1);
      chk("reset ctrl", 12'h000, ctrl);
      wr_cfg(12'h249);
      chk("ctrl", 12'h249, ctrl);
      chk("outputs", 12'h00f, {8'h00, hs});
      for (n = 1; n < 5; n = n + 1) begin
         mode <= n[2:0];
         wr_cfg(12'h492);
         chk("mode outputs", n < 3 ? 12'h00f : 12'h000, {8'h00, hs});
         chk("held ctrl", 12'h249, ctrl);
         mode <= `MODE_NORMAL;
         wr_cfg(12'h249);
         chk("re-enabled", 12'h00f, {8'h00, hs});
      end
      $display("test modes done");
      {ov_dis, ov_pin} <= 2'b11;
      step(6);
      chk("ov disabled", 12'h00f, {8'h00, hs});
      {mode, ov_dis} <= {`MODE_STOP, 1'b0};
      step(6);
      chk("ov off", 12'h000, {8'h00, hs});
      chk("ov flags", 12'h010, {7'h00, ovf, ocf});
      ov_pin <= 1'b0;
      step(6);
      chk("ov resume", 12'h00f, {8'h00, hs});
      {mode, rec_en, uv_pin} <= {`MODE_NORMAL, 2'b01};
      step(6);
      chk("uv off", 12'h000, {8'h00, hs});
      chk("uv flags", 12'h003, {10'h000, ovf, uvf});
      uv_pin <= 1'b0;
      c2 = 0;
      for (n = 0; n < 6; n = n + 1) begin
         step(1);
         c2 = c2 + (hs != 4'h0);
      end
      chk("uv stays off", 12'h000, c2[11:0]);
      chk("uv cleared", 12'h000, ctrl);
      chk("ol while off", 12'h000, {8'h00, olf});
      sf_clr <= 1'b1;
      step(1);
      chk("supply flags clear", 12'h000, {10'h000, ovf, uvf});
      sf_clr <= 1'b0;
      wr_cfg(12'h249);
      $display("test supply done");
      shrt <= 4'h1;
      n = 0;
      while (ocf[0] !== 1'b1 && n < 50) begin
         step(1);
         n = n + 1;
      end
      if (n == 50) begin
         miscompares = miscompares + 1;
         give_verdict;
      end
      step(2);
      chk("oc ctrl", 12'h248, ctrl);
      chk("oc outputs", 12'h00e, {8'h00, hs});
      {shrt, oc_clr} <= 8'h01;
      step(1);
      oc_clr <= 4'h0;
      wr_cfg(12'h249);
      chk("oc restart", 12'h00f, {4'h0, ocf, hs});
      opn <= 4'h3;
      step(20);
      chk("open load", 12'h03f, {4'h0, olf, hs});
      ol_clr <= 4'h3;
      step(2);
      chk("ol set wins", 12'h003, {8'h00, olf});
      opn <= 4'h0;
      step(5);
      ol_clr <= 4'h0;
      step(1);
      chk("ol cleared", 12'h000, {8'h00, olf});
      $display("test protection done");
      {t1, t2} <= 2'b10;
      wr_cfg(12'hb1a);
      step(1);
      chk("timer1", 12'h001, {10'h000, hs[1:0]});
      {t1, t2} <= 2'b01;
      step(3);
      chk("timer2", 12'h002, {10'h000, hs[1:0]});
      pwm_run(8'h40, 8'hc0, 2'b01, 12'h100, 12'h300);
      pwm_run(8'h80, 8'h80, 2'b10, 12'h200, 12'h200);
      $display("test pwm done");
      give_verdict;
   end
endmodule // tb_high_side_switch_control
`default_nettype wire
